// File: hdl/wdg_defines.svh
// constants for the watchdog control and status block
`ifndef WDG_DEFINES_SVH
`define WDG_DEFINES_SVH
`define WDG_ADDR_CONTROL 8'h00
`define WDG_ADDR_STATUS 8'h01
`define WDG_STATUS_RESET 8'h00
`define WDG_CONTROL_RESET 8'h00
`define WDG_LOCK_BIT 7
`define WDG_BUSY_BIT 0
`define WDG_PERIOD_LSB 0
`define WDG_WINDOW_LSB 4
`define WDG_CODE_MAX 4'hB
`define WDG_BASE_TICKS 14'h0008
`define WDG_SYNC_TICKS 2'h2
`define WDG_COUNT_W 14
`endif

// File: hdl/wdg_pkg.sv
// types for the watchdog control and status block
package wdg_pkg;
  typedef enum logic [2:0] {
    WDG_OFF,
    WDG_NORMAL,
    WDG_WAIT_FIRST,
    WDG_CLOSED,
    WDG_OPEN
  } wdg_state_t;
  typedef logic [3:0] wdg_code_t;
endpackage : wdg_pkg

// File: hdl/wdg_period_lut.sv
// timeout select code to watchdog tick count
`timescale 1ns/1ps
`include "wdg_defines.svh"
module wdg_period_lut
  import wdg_pkg::*;
(
  input wire wdg_code_t i_code,
  output logic [`WDG_COUNT_W-1:0] o_ticks,
  output logic o_valid
);
  // (RL13) count 8 shl n-1
  function automatic logic [`WDG_COUNT_W-1:0] wdg_ticks(input wdg_code_t code);
    wdg_ticks = `WDG_BASE_TICKS << (code - 4'h1);
  endfunction : wdg_ticks

  always_comb begin
    // (RL1) codes above eleven reserved
    o_valid = (i_code != 4'h0) && (i_code <= `WDG_CODE_MAX);
    o_ticks = o_valid ? wdg_ticks(i_code) : '0;
  end
endmodule : wdg_period_lut

// File: hdl/wdg_top.sv
// watchdog control, lock, sync busy flag and timeout counter
//
// Notes on behaviour
// (RL1) select codes 6..11 give 256 to 8192 ticks; codes above 11 disable.
// (RL2) lock bit 7 set makes control writes ignored.
// (RL3) lock set by software or automatically at boot; cleared only in debug mode.
// (RL4) nonzero period after boot sets lock automatically.
// (RL5) lock writes take effect only with the change guard open.
// (RL6) control write raises sync pending flag bit 0.
// (RL7) flag clears once control reaches the watchdog tick domain.
// (RL8) flag read-only, needs no guard; status resets to zero.
// (RL9) normal mode: missing restart before timeout gives system reset.
// (RL10) window mode: restart in closed period gives system reset.
// (RL11) restart takes two watchdog ticks; restarts meanwhile ignored.
// (RL12) software opens the change guard before protected writes.
// (RL13) timeout for code n is 8 shl n-1 watchdog ticks.
`timescale 1ns/1ps
`include "wdg_defines.svh"
module wdg_top
  import wdg_pkg::*;
(
  input wire logic i_clock,
  input wire logic i_reset,
  input wire logic [7:0] i_addr,
  input wire logic [7:0] i_wdata,
  input wire logic i_write,
  input wire logic i_read,
  output logic [7:0] o_rdata,
  input wire logic i_guard_open,
  input wire logic i_debug_mode,
  input wire logic i_boot_done,
  input wire logic [7:0] i_fuse_control,
  input wire logic i_restart,
  input wire logic i_wdt_clock,
  output logic o_system_reset,
  output logic o_enabled
);
  logic [7:0] control_q;
  logic lock_q;
  logic busy_q;
  logic boot_q;
  logic [2:0] wclk_q;
  logic tick;
  logic [1:0] csync_q;
  logic [7:0] shadow_q;
  logic rpend_q;
  logic [1:0] rsync_q;
  logic restart_apply;
  logic [`WDG_COUNT_W-1:0] count_q;
  wdg_state_t state_q;
  wdg_state_t state_d;
  logic [`WDG_COUNT_W-1:0] per_ticks;
  logic [`WDG_COUNT_W-1:0] win_ticks;
  logic per_valid;
  logic win_valid;
  logic [`WDG_COUNT_W-1:0] limit;
  logic expire;
  logic bite_d;
  logic clear_cnt;
  logic [7:0] rdata_q;
  logic enabled_q;
  logic wr_ctrl;
  logic wr_stat;
  logic ctrl_ok;

  always_comb begin
    wr_ctrl = i_write && (i_addr == `WDG_ADDR_CONTROL);
    wr_stat = i_write && (i_addr == `WDG_ADDR_STATUS);
    // (RL2) locked control ignores writes
    ctrl_ok = wr_ctrl && i_guard_open && !lock_q && !busy_q;
  end

  // watchdog clock pin synchroniser and rising edge
  always_ff @(posedge i_clock) begin
    if (i_reset) begin
      wclk_q <= 3'h0;
    end else begin
      wclk_q <= {wclk_q[1:0], i_wdt_clock};
    end
  end
  assign tick = wclk_q[1] && !wclk_q[2];

  // control register and boot load
  always_ff @(posedge i_clock) begin
    if (i_reset) begin
      control_q <= `WDG_CONTROL_RESET;
      boot_q <= 1'b0;
    end else begin
      boot_q <= boot_q | i_boot_done;
      if (i_boot_done && !boot_q) begin
        control_q <= i_fuse_control;
      end else if (ctrl_ok) begin
        control_q <= i_wdata;
      end
    end
  end

  // lock bit
  always_ff @(posedge i_clock) begin
    if (i_reset) begin
      // (RL8) status resets to zero
      lock_q <= 1'b0;
    end else if (i_boot_done && !boot_q && (i_fuse_control[3:0] != 4'h0)) begin
      // (RL4) automatic lock after boot
      lock_q <= 1'b1;
    end else if (wr_stat && i_guard_open) begin
      // (RL5) guarded lock write
      if (i_wdata[`WDG_LOCK_BIT]) begin
        lock_q <= 1'b1;
      end else if (i_debug_mode) begin
        // (RL3) clear only in debug
        lock_q <= 1'b0;
      end
    end
  end

  // control crossing into tick domain
  always_ff @(posedge i_clock) begin
    if (i_reset) begin
      busy_q <= 1'b0;
      csync_q <= 2'h0;
      shadow_q <= `WDG_CONTROL_RESET;
    end else if (ctrl_ok || (i_boot_done && !boot_q)) begin
      // (RL6) raise sync pending
      busy_q <= 1'b1;
      csync_q <= 2'h0;
    end else if (busy_q && tick) begin
      if (csync_q == `WDG_SYNC_TICKS - 2'h1) begin
        // (RL7) transfer done, clear
        busy_q <= 1'b0;
        shadow_q <= control_q;
      end
      csync_q <= csync_q + 2'h1;
    end
  end

  // restart synchroniser
  always_ff @(posedge i_clock) begin
    if (i_reset) begin
      rpend_q <= 1'b0;
      rsync_q <= 2'h0;
    end else if (!rpend_q) begin
      rpend_q <= i_restart;
      rsync_q <= 2'h0;
    end else if (tick) begin
      // (RL11) second restart ignored while pending
      if (rsync_q == `WDG_SYNC_TICKS - 2'h1) begin
        rpend_q <= 1'b0;
      end
      rsync_q <= rsync_q + 2'h1;
    end
  end
  assign restart_apply = rpend_q && tick && (rsync_q == `WDG_SYNC_TICKS - 2'h1);

  wdg_period_lut u_per (
    .i_code(shadow_q[`WDG_PERIOD_LSB+3:`WDG_PERIOD_LSB]),
    .o_ticks(per_ticks),
    .o_valid(per_valid)
  );

  wdg_period_lut u_win (
    .i_code(shadow_q[`WDG_WINDOW_LSB+3:`WDG_WINDOW_LSB]),
    .o_ticks(win_ticks),
    .o_valid(win_valid)
  );

  always_comb begin
    limit = (state_q == WDG_CLOSED) ? win_ticks : per_ticks;
    expire = tick && (count_q >= limit - `WDG_COUNT_W'(1));
    state_d = state_q;
    bite_d = 1'b0;
    clear_cnt = 1'b0;
    if (!per_valid) begin
      state_d = WDG_OFF;
      clear_cnt = 1'b1;
    end else if (i_debug_mode) begin
      state_d = win_valid ? WDG_WAIT_FIRST : WDG_NORMAL;
      clear_cnt = 1'b1;
    end else begin
      case (state_q)
        WDG_OFF: begin
          state_d = win_valid ? WDG_WAIT_FIRST : WDG_NORMAL;
          clear_cnt = 1'b1;
        end
        WDG_NORMAL: begin
          // (RL9) restart or timeout bite
          if (win_valid) begin
            state_d = WDG_WAIT_FIRST;
            clear_cnt = 1'b1;
          end else if (restart_apply) begin
            clear_cnt = 1'b1;
          end else if (expire) begin
            bite_d = 1'b1;
            clear_cnt = 1'b1;
          end
        end
        WDG_CLOSED: begin
          // (RL10) restart in closed bites
          if (restart_apply) begin
            bite_d = 1'b1;
            state_d = WDG_WAIT_FIRST;
            clear_cnt = 1'b1;
          end else if (expire) begin
            state_d = WDG_OPEN;
            clear_cnt = 1'b1;
          end
        end
        default: begin
          // window wait-first and open periods
          if (!win_valid) begin
            state_d = WDG_NORMAL;
            clear_cnt = 1'b1;
          end else if (restart_apply) begin
            state_d = WDG_CLOSED;
            clear_cnt = 1'b1;
          end else if (expire) begin
            bite_d = 1'b1;
            state_d = WDG_WAIT_FIRST;
            clear_cnt = 1'b1;
          end
        end
      endcase
    end
  end

  // timeout counter and state
  always_ff @(posedge i_clock) begin
    if (i_reset) begin
      state_q <= WDG_OFF;
      count_q <= '0;
      o_system_reset <= 1'b0;
      enabled_q <= 1'b0;
    end else begin
      state_q <= state_d;
      o_system_reset <= bite_d;
      enabled_q <= (state_d != WDG_OFF);
      if (clear_cnt) begin
        count_q <= '0;
      end else if (tick) begin
        count_q <= count_q + `WDG_COUNT_W'(1);
      end
    end
  end
  assign o_enabled = enabled_q;

  // register read port, data one cycle after strobe
  always_ff @(posedge i_clock) begin
    if (i_reset) begin
      rdata_q <= 8'h00;
    end else if (i_read && (i_addr == `WDG_ADDR_CONTROL)) begin
      rdata_q <= control_q;
    end else if (i_read && (i_addr == `WDG_ADDR_STATUS)) begin
      // (RL8) busy flag read only
      rdata_q <= {lock_q, 6'h00, busy_q};
    end else begin
      rdata_q <= 8'h00;
    end
  end
  assign o_rdata = rdata_q;
endmodule : wdg_top

// File: bench/wdg_checker.sv
// port checks for the watchdog block
`timescale 1ns/1ps
module wdg_checker (
  input wire logic i_clock,
  input wire logic i_reset,
  input wire logic [7:0] i_addr,
  input wire logic i_read,
  input wire logic i_debug_mode,
  input wire logic i_wdt_clock,
  input wire logic [7:0] o_rdata,
  input wire logic o_system_reset,
  input wire logic o_enabled
);
  default clocking @(posedge i_clock); endclocking
  default disable iff (i_reset);
  sequence s_pin_high;
    $past(i_wdt_clock, 2) || $past(i_wdt_clock, 3) || $past(i_wdt_clock, 4);
  endsequence
  a_rdata_idle: assert property (!$past(i_read) |-> o_rdata == 8'h00)
    else $error("rdata not idle");
  a_rdata_unmapped: assert property ($past(i_read) && $past(i_addr) > 8'h01 |-> o_rdata == 8'h00)
    else $error("unmapped rdata");
  a_status_spare: assert property ($past(i_read) && $past(i_addr) == 8'h01 |-> !o_rdata[6:1])
    else $error("status spare bits");
  a_bite_gap: assert property (o_system_reset |=> !o_system_reset [*8])
    else $error("bite too long");
  a_bite_enabled: assert property (o_system_reset |-> $past(o_enabled))
    else $error("bite while off");
  a_bite_tick: assert property (o_system_reset |-> s_pin_high)
    else $error("bite off tick");
  a_enable_tick: assert property ($changed(o_enabled) |-> s_pin_high)
    else $error("enable off tick");
  a_debug_quiet: assert property (i_debug_mode [*4] |-> !o_system_reset)
    else $error("bite in debug");
endmodule : wdg_checker

// File: bench/wdg_cpu_model.sv
// cpu side: key write opens the change guard
`timescale 1ns/1ps
module wdg_cpu_model (
  input wire logic i_clock,
  input wire logic i_reset,
  input wire logic i_key,
  output logic o_guard_open
);
  logic [2:0] left_q;
  always_ff @(posedge i_clock) begin
    if (i_reset) begin
      left_q <= 3'h0;
    end else if (i_key) begin
      left_q <= 3'h4;
    end else if (left_q != 3'h0) begin
      left_q <= left_q - 3'h1;
    end
  end
  assign o_guard_open = (left_q != 3'h0);
endmodule : wdg_cpu_model

// File: bench/wdg_top_test.sv
// self-checking bench for the watchdog block
`timescale 1ns/1ps
module wdg_top_test;
  logic i_clock = 1'b0, i_reset = 1'b1, i_write = 1'b0, i_read = 1'b0, key = 1'b0;
  logic i_debug_mode = 1'b0, i_boot_done = 1'b0, i_restart = 1'b0, i_wdt_clock = 1'b0;
  logic [7:0] i_addr = 8'h00, i_wdata = 8'h00, i_fuse_control = 8'h00, o_rdata;
  logic i_guard_open, o_system_reset, o_enabled;
  int fails = 0, tests_run = 0, n, m;
  initial begin
    forever #2 i_clock = ~i_clock;
  end
  initial begin
    forever #20 i_wdt_clock = ~i_wdt_clock;
  end
  wdg_cpu_model i_cpu (.i_clock(i_clock), .i_reset(i_reset), .i_key(key),
    .o_guard_open(i_guard_open));
  wdg_top i_dut (.i_clock(i_clock), .i_reset(i_reset), .i_addr(i_addr), .i_wdata(i_wdata),
    .i_write(i_write), .i_read(i_read), .o_rdata(o_rdata), .i_guard_open(i_guard_open),
    .i_debug_mode(i_debug_mode), .i_boot_done(i_boot_done), .i_fuse_control(i_fuse_control),
    .i_restart(i_restart), .i_wdt_clock(i_wdt_clock), .o_system_reset(o_system_reset),
    .o_enabled(o_enabled));
  task chk(string nm, logic [7:0] seen, logic [7:0] exp);
    tests_run++;
    if (seen !== exp) begin
      fails++;
      $display("wrong value %s expected %h seen %h", nm, exp, seen);
    end
  endtask : chk
  task cyc(int k);
    repeat (k) @(posedge i_clock);
  endtask : cyc
  task kick();
    i_restart <= 1'b1;
    cyc(1);
    i_restart <= 1'b0;
  endtask : kick
  task bites(int k);
    n = 0;
    repeat (k) begin
      cyc(1);
      #1;
      if (o_system_reset === 1'b1) n++;
    end
  endtask : bites
  task wr(logic [7:0] a, logic [7:0] d, logic g);
    key <= g;
    cyc(1);
    key <= 1'b0;
    i_write <= 1'b1;
    i_addr <= a;
    i_wdata <= d;
    cyc(1);
    i_write <= 1'b0;
  endtask : wr
  task rd(logic [7:0] a, logic [7:0] exp, string nm);
    i_read <= 1'b1;
    i_addr <= a;
    cyc(1);
    i_read <= 1'b0;
    #1 chk(nm, o_rdata, exp);
    cyc(1);
  endtask : rd
  task t_boot(logic [7:0] fuse, logic [7:0] lock);
    i_reset <= 1'b1;
    i_boot_done <= 1'b0;
    i_fuse_control <= fuse;
    cyc(2);
    i_reset <= 1'b0;
    rd(8'h01, 8'h00, "status reset");
    i_boot_done <= 1'b1;
    cyc(200);
    rd(8'h01, lock, "boot lock");
    rd(8'h00, fuse, "boot control");
  endtask : t_boot
  task t_sync();
    wr(8'h00, 8'h06, 1'b1);
    rd(8'h01, 8'h01, "busy set");
    cyc(200);
    rd(8'h01, 8'h00, "busy clear");
    chk("enabled", {7'h00, o_enabled}, 8'h01);
  endtask : t_sync
  task t_timeout();
    kick();
    n = 0;
    while (o_system_reset !== 1'b1 && n < 4000) begin
      cyc(1);
      #1 n++;
    end
    chk("bite time", 8'(n / 100), 8'h19);
  endtask : t_timeout
  task t_alive();
    m = 0;
    repeat (4) begin
      kick();
      bites(1000);
      m += n;
    end
    chk("kept alive", 8'(m), 8'h00);
  endtask : t_alive
  task t_window();
    wr(8'h00, 8'h33, 1'b1);
    cyc(100);
    kick();
    cyc(2);
    kick();
    bites(60);
    chk("restart while pending", 8'(n), 8'h00);
    kick();
    n = 0;
    while (o_system_reset !== 1'b1 && n < 100) begin
      cyc(1);
      #1 n++;
    end
    chk("closed restart bite", 8'((n > 10) && (n < 25)), 8'h01);
    kick();
    bites(400);
    chk("closed then open", 8'(n), 8'h00);
    kick();
    bites(100);
    chk("open restart", 8'(n), 8'h00);
  endtask : t_window
  task t_lock();
    wr(8'h01, 8'h80, 1'b0);
    rd(8'h01, 8'h00, "unguarded lock");
    wr(8'h01, 8'h80, 1'b1);
    wr(8'h00, 8'h07, 1'b1);
    rd(8'h00, 8'h06, "locked control");
    wr(8'h01, 8'h00, 1'b1);
    rd(8'h01, 8'h80, "lock kept");
    rd(8'h05, 8'h00, "unmapped");
    i_debug_mode <= 1'b1;
    wr(8'h01, 8'h00, 1'b1);
    rd(8'h01, 8'h00, "debug clear");
    i_debug_mode <= 1'b0;
    wr(8'h00, 8'h0C, 1'b1);
    cyc(200);
    chk("reserved off", {7'h00, o_enabled}, 8'h00);
  endtask : t_lock
  task tally_and_finish();
    $display("comparisons %0d mismatches %0d", tests_run, fails);
    if (fails == 0 && tests_run > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask : tally_and_finish
  initial begin
    t_boot(8'h00, 8'h00);
    t_sync();
    t_timeout();
    t_alive();
    t_lock();
    t_window();
    t_boot(8'h07, 8'h80);
    tally_and_finish();
  end
  initial begin
    #200us;
    fails++;
    tally_and_finish();
  end
endmodule : wdg_top_test
bind wdg_top wdg_checker i_chk (.i_clock(i_clock), .i_reset(i_reset), .i_addr(i_addr),
  .i_read(i_read), .i_debug_mode(i_debug_mode), .i_wdt_clock(i_wdt_clock),
  .o_rdata(o_rdata), .o_system_reset(o_system_reset), .o_enabled(o_enabled));
